// ### inc/emr_map.vh
// emergency message reporter constants: object ids, field positions, resets
// assumes inclusion by bare name from rtl files
`ifndef EMR_MAP_VH
`define EMR_MAP_VH
// object identifiers used as register selectors on the object port
`define EMR_IDX_FLAGS      16'h10f3
`define EMR_SUB_FLAGS      8'h05
`define EMR_IDX_CODE       16'h603f
`define EMR_SUB_CODE       8'h00
// flag word layout and reset
`define EMR_FLAG_EN_BIT    0
`define EMR_FLAGS_RESET    16'h0001
`define EMR_FLAGS_RO_MASK  16'h0006
// fault code composition
`define EMR_CODE_NONE      16'h0000
`define EMR_CODE_MFR_HI    8'hff
`define EMR_WARN_LO        8'ha0
`define EMR_WARN_HI        8'ha9
// queue depth while in init
`define EMR_QDEPTH         8
`define EMR_QPTR_W         3
// state machine codes for the link state
`define EMR_ESM_INIT       4'h1
`endif

// ### rtl/emr_reporter.v
// emergency message reporter: composes 8-byte messages from alarm state,
// holds up to eight while in init, sends when preop or higher and enabled.
// assumes alarm inputs are synchronous to clock; mailbox sink handshakes.
`timescale 1ns/1ps
`default_nettype none
`include "emr_map.vh"

module emr_reporter (
    input  wire        clock,
    input  wire        reset,
    input  wire        alarmActive,
    input  wire [7:0]  alarmMain,
    input  wire [7:0]  alarmSub,
    input  wire [15:0] alarmStdCode,
    input  wire        alarmStdSel,
    input  wire        warnActive,
    input  wire [7:0]  warnNum,
    input  wire [7:0]  errRegValue,
    input  wire [3:0]  esmState,
    input  wire        objWrite,
    input  wire [15:0] objIndex,
    input  wire [7:0]  objSub,
    input  wire [15:0] objWrData,
    output reg  [15:0] objRdData,
    output reg         objRdValid,
    output reg  [15:0] faultCode,
    output reg  [15:0] flagWord,
    output reg         msgValid,
    input  wire        msgReady,
    output reg  [63:0] msgData,
    output reg  [3:0]  queueCount,
    output reg         queueDropped
);

// ----------------------------------------------------------------------
// fault code composition
// ----------------------------------------------------------------------
    reg  [15:0] codeNxt;
    wire        warnInRange = (warnNum >= `EMR_WARN_LO) && (warnNum <= `EMR_WARN_HI);
    // alarm beats warning; standard codes pass straight through
    always @* begin
        if (alarmActive) begin
            if (alarmStdSel)
                codeNxt = alarmStdCode;
            else
                codeNxt = {`EMR_CODE_MFR_HI, alarmMain};
        end else if (warnActive && warnInRange) begin
            codeNxt = {`EMR_CODE_MFR_HI, warnNum};
        end else begin
            codeNxt = `EMR_CODE_NONE;
        end
    end

    // object register outputs, flag word bit0 writable only
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            faultCode  <= `EMR_CODE_NONE;
            flagWord   <= `EMR_FLAGS_RESET;
            objRdData  <= 16'h0000;
            objRdValid <= 1'b0;
        end else begin
            faultCode  <= codeNxt;
            objRdValid <= 1'b0;
            if (objWrite && objIndex == `EMR_IDX_FLAGS && objSub == `EMR_SUB_FLAGS)
                flagWord <= (objWrData & 16'h0001) | `EMR_FLAGS_RO_MASK;
            if (!objWrite && objIndex == `EMR_IDX_FLAGS && objSub == `EMR_SUB_FLAGS) begin
                objRdData  <= flagWord;
                objRdValid <= 1'b1;
            end else if (!objWrite && objIndex == `EMR_IDX_CODE &&
                         objSub == `EMR_SUB_CODE) begin
                objRdData  <= faultCode;
                objRdValid <= 1'b1;
            end
        end
    end

// ----------------------------------------------------------------------
// event detection
// ----------------------------------------------------------------------
    // an event is an alarm rise, a change of alarm, or an alarm clear;
    // warning-only changes are ignored on purpose
    reg         alarmPrev_r;
    reg  [15:0] codePrev_r;
    wire        alarmEvent = (alarmActive && (!alarmPrev_r || codeNxt != codePrev_r)) ||
                             (!alarmActive && alarmPrev_r);
    wire [7:0]  fieldByte0 = alarmActive ? alarmSub : 8'h00;
    wire [15:0] msgCode    = alarmActive ? codeNxt : codeNxt;
    wire [63:0] newMsg     = {msgCode, errRegValue, fieldByte0, 32'h00000000};
    wire        txEnable   = flagWord[`EMR_FLAG_EN_BIT];
    wire        inInit     = (esmState == `EMR_ESM_INIT);

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            alarmPrev_r <= 1'b0;
            codePrev_r  <= 16'h0000;
        end else begin
            alarmPrev_r <= alarmActive;
            codePrev_r  <= codeNxt;
        end
    end

// ----------------------------------------------------------------------
// init queue, eight entries
// ----------------------------------------------------------------------
    reg  [63:0]          qMem [0:`EMR_QDEPTH-1];
    reg  [`EMR_QPTR_W-1:0] qRd_r;
    reg  [`EMR_QPTR_W-1:0] qWr_r;
    wire                 qFull  = (queueCount == 4'd8);
    wire                 qEmpty = (queueCount == 4'd0);
    // pending holds the latest live event; overwriting keeps final status
    reg                  pend_r;
    reg  [63:0]          pendMsg_r;
    wire                 push   = alarmEvent && txEnable && inInit && !qFull;
    wire                 canSend = !inInit && txEnable && (!msgValid || msgReady);
    wire                 popQ   = canSend && !qEmpty;
    wire                 sendPend = canSend && qEmpty && pend_r;

    // queue storage; written only, no reset needed for data
    always @(posedge clock) begin
        if (push)
            qMem[qWr_r] <= newMsg;
    end

    // pointers and count; older entries kept, newer dropped when full
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            qRd_r        <= 3'd0;
            qWr_r        <= 3'd0;
            queueCount   <= 4'd0;
            queueDropped <= 1'b0;
        end else begin
            if (push)
                qWr_r <= qWr_r + 3'd1;
            if (popQ)
                qRd_r <= qRd_r + 3'd1;
            queueCount <= queueCount + {3'd0, push} - {3'd0, popQ};
            if (alarmEvent && txEnable && inInit && qFull)
                queueDropped <= 1'b1;
            else if (!inInit && qEmpty)
                queueDropped <= 1'b0;
        end
    end

// ----------------------------------------------------------------------
// transmit path toward the mailbox
// ----------------------------------------------------------------------
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            pend_r    <= 1'b0;
            pendMsg_r <= 64'h0000000000000000;
            msgValid  <= 1'b0;
            msgData   <= 64'h0000000000000000;
        end else begin
            if (msgValid && msgReady)
                msgValid <= 1'b0;
            // event while live: newest wins if not yet sent
            if (alarmEvent && txEnable && !inInit) begin
                pend_r    <= 1'b1;
                pendMsg_r <= newMsg;
            end else if (sendPend) begin
                pend_r <= 1'b0;
            end
            if (!txEnable)
                pend_r <= 1'b0;
            if (popQ) begin
                msgValid <= 1'b1;
                msgData  <= qMem[qRd_r];
            end else if (sendPend) begin
                msgValid <= 1'b1;
                msgData  <= pendMsg_r;
            end
        end
    end

endmodule // emr_reporter
`default_nettype wire

// ### tb/emr_reporter_checker.sv
// port assertions for the emergency message reporter
// assumes it is bound into emr_reporter and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module emr_reporter_checker (
    input wire logic        clock, reset, alarmActive, alarmStdSel, warnActive,
    input wire logic        objRdValid, msgValid, msgReady,
    input wire logic [3:0]  esmState, queueCount,
    input wire logic [7:0]  alarmMain,
    input wire logic [15:0] alarmStdCode, objIndex, objRdData, faultCode,
    input wire logic [63:0] msgData
);
    // one domain, so reset masks every check at once
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence stall_s; msgValid && !msgReady; endsequence
    sequence code_rd_s; objRdValid && $past(objIndex) == 16'h603f; endsequence
    hold_msg_a: assert property (stall_s |=> msgValid && $stable(msgData))
        else $error("message changed while stalled");
    field_tail_a: assert property (msgValid |-> msgData[31:0] == 32'h0)
        else $error("error field tail not zero");
    idle_code_a: assert property (
        !alarmActive && !warnActive |=> faultCode == 16'h0000)
        else $error("fault code not zero when idle");
    maker_code_a: assert property (
        alarmActive && !alarmStdSel |=> faultCode == {8'hff, $past(alarmMain)})
        else $error("maker code wrong");
    std_code_a: assert property (
        alarmActive && alarmStdSel |=> faultCode == $past(alarmStdCode))
        else $error("standard code wrong");
    full_hold_a: assert property (
        queueCount == 4'h8 && esmState == 4'h1 |=> queueCount == 4'h8)
        else $error("full queue changed in init");
    init_quiet_a: assert property (esmState == 4'h1 && !msgValid |=> !msgValid)
        else $error("message sent in init");
    code_read_a: assert property (code_rd_s |-> objRdData == $past(faultCode))
        else $error("fault code readback wrong");
endmodule // emr_reporter_checker
bind emr_reporter emr_reporter_checker u_chk (.*);
`default_nettype wire

// ### tb/emr_mbx_sink.sv
// mailbox sink model: one whole 8-byte message per ready handshake
// assumes the bench drives stall away from the sampling edge
`timescale 1ns/1ps
`default_nettype none
module emr_mbx_sink (
    input  wire logic        clock, stall, msgValid,
    input  wire logic [63:0] msgData,
    output wire logic        msgReady
);
    logic [63:0] got[$];
    // a stalled master holds ready low; the reporter must keep its message
    assign msgReady = !stall;
    always @(posedge clock) if (msgValid && msgReady) got.push_back(msgData);
endmodule // emr_mbx_sink
`default_nettype wire

// ### tb/tb_emr_reporter.sv
// bench: drives the reporter, checks readback and sent messages
// assumes emr_mbx_sink queues accepted messages in order
`timescale 1ns/1ps
`default_nettype none
module tb_emr_reporter;
    logic        clock = 1'b0, reset, alarmActive, alarmStdSel, warnActive, objWrite, stall;
    logic        objRdValid, msgValid, msgReady, queueDropped;
    logic [3:0]  esmState, queueCount;
    logic [7:0]  alarmMain, alarmSub, warnNum, errRegValue, objSub;
    logic [15:0] alarmStdCode, objIndex, objWrData, objRdData, faultCode, flagWord;
    logic [63:0] msgData;
    int          err_count = 0, num_checks = 0, cyc = 0;
    emr_reporter u_dut (.*);
    emr_mbx_sink u_sink (.*);
    // 40 ns clock; the cycle cap turns a hang into a failure
    always #20 clock = ~clock;
    always @(posedge clock) if (++cyc == 3000) tally_and_finish(1);
    task automatic tally_and_finish(input int extra);
        err_count += extra;
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) err_count++;
        if (g !== e) $display("unexpected %s exp %h got %h", nm, e, g);
    endtask
    // write pulse (or read), then readback two falling edges on
    task automatic obj(input logic w, input logic [39:0] a, input logic [15:0] e);
        {objWrite, objIndex, objSub, objWrData} = {w, a};
        @(negedge clock);
        objWrite = 1'b0;
        @(negedge clock);
        chk("objRdData", 64'(e), 64'(objRdData));
    endtask
    // gaps of four cycles keep events apart, so none coalesce
    task automatic al(input logic a, input logic [7:0] m);
        {alarmActive, alarmMain, alarmSub} = {a, m, m + 8'h01};
        repeat (4) @(negedge clock);
    endtask
    task automatic getm(input logic [63:0] e);
        for (int n = 0; n < 40 && u_sink.got.size() == 0; n++) @(negedge clock);
        chk("msgData", e, u_sink.got.size() != 0 ? u_sink.got.pop_front() : 64'hx);
    endtask
    initial begin
        {reset, alarmActive, alarmStdSel, warnActive, objWrite, stall} = 6'h20;
        {alarmMain, alarmSub, warnNum, errRegValue, objSub, esmState} = 44'h2;
        {alarmStdCode, objIndex, objWrData} = 48'h0;
        repeat (10) @(negedge clock);
        reset = 1'b0;
        obj(1'b0, 40'h10f3050000, 16'h0001);
        chk("flagWord", 64'h1, 64'(flagWord));
        obj(1'b0, 40'h603f000000, 16'h0000);
        errRegValue = 8'h80;
        al(1'b1, 8'h10);
        getm(64'hff10_8011_0000_0000);
        errRegValue = 8'h00;
        al(1'b0, 8'h10);
        getm(64'h0);
        {warnActive, warnNum} = 9'h1a3;
        obj(1'b0, 40'h603f000000, 16'hffa3);
        warnActive = 1'b0;
        repeat (8) @(negedge clock);
        chk("queued", 64'h0, 64'(u_sink.got.size()));
        obj(1'b1, 40'h10f3050000, 16'h0006);
        {alarmStdSel, alarmStdCode} = 17'h1_2310;
        al(1'b1, 8'h20);
        obj(1'b0, 40'h603f000000, 16'h2310);
        al(1'b0, 8'h20);
        chk("queued", 64'h0, 64'(u_sink.got.size()));
        {alarmStdSel, esmState, stall, errRegValue} = {1'b0, 4'h1, 1'b1, 8'h80};
        obj(1'b1, 40'h10f3050001, 16'h0007);
        chk("flagWord", 64'h7, 64'(flagWord));
        for (int i = 1; i <= 5; i++) begin
            al(1'b1, i[7:0]);
            al(1'b0, i[7:0]);
        end
        chk("queueCount", 64'h8, 64'(queueCount));
        chk("queueDropped", 64'h1, 64'(queueDropped));
        esmState = 4'h2;
        repeat (6) @(negedge clock);
        stall = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            getm({8'hff, i[7:0], 8'h80, i[7:0] + 8'h01, 32'h0});
            getm({16'h0000, 8'h80, 40'h0});
        end
        chk("queueDropped", 64'h0, 64'(queueDropped));
        // stalled sink: a change then a clear coalesce into the final status
        stall = 1'b1;
        {alarmActive, alarmMain, alarmSub} = {1'b1, 8'h30, 8'h31};
        repeat (3) @(negedge clock);
        {alarmMain, alarmSub} = 16'h4041;
        @(negedge clock);
        alarmActive = 1'b0;
        repeat (4) @(negedge clock);
        stall = 1'b0;
        getm(64'hff30_8031_0000_0000);
        getm({16'h0000, 8'h80, 40'h0});
        repeat (6) @(negedge clock);
        chk("queued", 64'h0, 64'(u_sink.got.size()));
        tally_and_finish(0);
    end
endmodule // tb_emr_reporter
`default_nettype wire
